/* File: sep_regs.svh */
// Constants shared by both ends of the serial EEPROM read path
`ifndef SEP_REGS_SVH
`define SEP_REGS_SVH

// Address byte layout
`define SEP_FAMILY       4'ha
`define SEP_DIR_RD       1'b1
`define SEP_DIR_WR       1'b0
`define SEP_ACK          1'b0
`define SEP_NACK         1'b1

// Bit counts within one byte slot
`define SEP_CNT_ZERO     4'h0
`define SEP_CNT_ONE      4'h1
`define SEP_BITS_BYTE    4'h8
`define SEP_CNT_ACK      4'h9

// Power-up value of the word-address counter
`define SEP_ADDR_RST     8'h00

// Link clock made by the controller
`define SEP_CLK_NS       8
`define SEP_SCL_NS       160
`define SEP_QTR_CYC      ((`SEP_SCL_NS) / (4 * `SEP_CLK_NS))

`endif

/* File: sep_pkg.sv */
// Types for the serial EEPROM read path
`default_nettype none
package sep_pkg;

  typedef enum logic [2:0] {
    SD_IDLE  = 3'b000,
    SD_DEV   = 3'b001,
    SD_WORD  = 3'b010,
    SD_WDATA = 3'b011,
    SD_ACK   = 3'b100,
    SD_RDATA = 3'b101,
    SD_RACK  = 3'b110
  } sep_dev_state_e;

  typedef enum logic [1:0] {
    SH_IDLE  = 2'b00,
    SH_START = 2'b01,
    SH_BYTE  = 2'b10,
    SH_STOP  = 2'b11
  } sep_host_state_e;

  typedef enum logic [2:0] {
    SS_DEVW = 3'b000,
    SS_WORD = 3'b001,
    SS_DATA = 3'b010,
    SS_DEVR = 3'b011,
    SS_READ = 3'b100
  } sep_step_e;

  typedef enum logic [1:0] {
    SK_CUR   = 2'b00,
    SK_RAND  = 2'b01,
    SK_WRITE = 2'b10
  } sep_kind_e;

endpackage : sep_pkg
`default_nettype wire

/* File: sep_link_if.sv */
// Two-wire link between controller and EEPROM target
`timescale 1ns/1ps
`default_nettype none
interface sep_link_if;
  logic scl;
  logic host_sda_oe_n;
  logic dev_sda_oe_n;
  logic sda;

  // Open drain with pull-up: low when either end enables its driver
  assign sda = host_sda_oe_n & dev_sda_oe_n;

  modport dev (input scl, input sda, output dev_sda_oe_n);
  modport host (output scl, output host_sda_oe_n, input sda);
endinterface : sep_link_if
`default_nettype wire

/* File: sep_dev.sv */
// EEPROM target end: address counter, read forms and write roll-over
// How it works
// - Read is a write with direction high
// - Counter holds last accessed address plus one
// - Counter kept across transactions until power-off
// - Read increment wraps top to address zero
// - Write increment wraps within current page
// - Matching read address acked, then data out
// - Controller ends single read with NACK, stop
// - Random read loads address by dummy write
// - Then repeated start and read address
// - Ack read address, send newly loaded byte
// - Controller ack makes device send next byte
// - Sequential read wraps and continues
// - NACK releases data line and ends sending
// - Family nibble, strap bits, direction bit
// - Mismatch: no ack, idle till start
// - Eight bits, ack low on ninth clock
// - Write increments only low three bits
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.svh"
module sep_dev #(
  parameter int ADDR_W    = 7,
  parameter int DEPTH     = 128,
  parameter int PAGE_BITS = 3
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              strap_addr_bit2,
  input  wire logic              strap_addr_bit1,
  input  wire logic              strap_addr_bit0,
  output logic [ADDR_W-1:0]      cur_addr,
  sep_link_if.dev                link
);
  import sep_pkg::*;

  logic [2:0]          scl_sy_ff;
  logic [2:0]          sda_sy_ff;
  logic [2:0]          strap_sy1_ff;
  logic [2:0]          strap_sy2_ff;
  sep_dev_state_e      state_ff;
  sep_dev_state_e      nxt_state;
  sep_dev_state_e      after_ff;
  sep_dev_state_e      nxt_after;
  logic [3:0]          cnt_ff;
  logic [3:0]          nxt_cnt;
  logic [7:0]          sr_ff;
  logic [7:0]          nxt_sr;
  logic                oe_n_ff;
  logic                nxt_oe_n;
  logic [ADDR_W-1:0]   addr_ff;
  logic [ADDR_W-1:0]   nxt_addr;
  logic                mack_ff;
  logic                nxt_mack;
  logic                mem_we;
  logic [7:0]          mem [DEPTH];

  wire                 scl_s      = scl_sy_ff[1];
  wire                 sda_s      = sda_sy_ff[1];
  wire                 scl_rise   = scl_sy_ff[1] & ~scl_sy_ff[2];
  wire                 scl_fall   = ~scl_sy_ff[1] & scl_sy_ff[2];
  wire                 start_det  = scl_s & scl_sy_ff[2] & ~sda_sy_ff[1] & sda_sy_ff[2];
  wire                 stop_det   = scl_s & scl_sy_ff[2] & sda_sy_ff[1] & ~sda_sy_ff[2];
  wire                 byte_done  = (cnt_ff == `SEP_BITS_BYTE);
  wire                 rx_shift   = scl_rise & ~byte_done;
  wire                 rx_end     = scl_fall & byte_done;
  wire                 ack_end    = scl_fall & (cnt_ff == `SEP_CNT_ACK);
  wire [7:0]           rd_byte    = mem[addr_ff];
  wire                 dev_match  = (sr_ff[7:4] == `SEP_FAMILY) && (sr_ff[3:1] == strap_sy2_ff);
  wire                 dir_rd     = (sr_ff[0] == `SEP_DIR_RD);
  wire [ADDR_W-1:0]    rd_inc     = addr_ff + 1'b1;
  wire [PAGE_BITS-1:0] page_lo    = addr_ff[PAGE_BITS-1:0] + 1'b1;
  wire [ADDR_W-1:0]    wr_inc     = {addr_ff[ADDR_W-1:PAGE_BITS], page_lo};

  // Pins cross into ref_clk through two flops; third flop gives edges
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_sy_ff    <= 3'h7;
      sda_sy_ff    <= 3'h7;
      strap_sy1_ff <= 3'h0;
      strap_sy2_ff <= 3'h0;
    end else begin
      scl_sy_ff    <= {scl_sy_ff[1:0], link.scl};
      sda_sy_ff    <= {sda_sy_ff[1:0], link.sda};
      strap_sy1_ff <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
      strap_sy2_ff <= strap_sy1_ff;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_after = after_ff;
    nxt_cnt   = cnt_ff;
    nxt_sr    = sr_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_addr  = addr_ff;
    nxt_mack  = mack_ff;
    mem_we    = 1'b0;
    if (start_det) begin
      nxt_state = SD_DEV;
      nxt_cnt   = `SEP_CNT_ZERO;
      nxt_oe_n  = 1'b1;
    end else if (stop_det) begin
      nxt_state = SD_IDLE;
      nxt_cnt   = `SEP_CNT_ZERO;
      nxt_oe_n  = 1'b1;
    end else begin
      case (state_ff)
        SD_IDLE: begin
          nxt_oe_n = 1'b1;
        end
        SD_DEV: begin
          if (rx_shift) begin
            nxt_sr  = {sr_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + `SEP_CNT_ONE;
          end else if (rx_end) begin
            if (dev_match) begin
              nxt_state = SD_ACK;
              nxt_after = dir_rd ? SD_RDATA : SD_WORD;
              nxt_oe_n  = `SEP_ACK;
            end else begin
              nxt_state = SD_IDLE;
              nxt_cnt   = `SEP_CNT_ZERO;
            end
          end
        end
        SD_WORD: begin
          if (rx_shift) begin
            nxt_sr  = {sr_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + `SEP_CNT_ONE;
          end else if (rx_end) begin
            nxt_addr  = sr_ff[ADDR_W-1:0];
            nxt_state = SD_ACK;
            nxt_after = SD_WDATA;
            nxt_oe_n  = `SEP_ACK;
          end
        end
        SD_WDATA: begin
          if (rx_shift) begin
            nxt_sr  = {sr_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + `SEP_CNT_ONE;
          end else if (rx_end) begin
            mem_we    = 1'b1;
            nxt_addr  = wr_inc;
            nxt_state = SD_ACK;
            nxt_after = SD_WDATA;
            nxt_oe_n  = `SEP_ACK;
          end
        end
        SD_ACK: begin
          if (scl_rise) begin
            nxt_cnt = `SEP_CNT_ACK;
          end else if (ack_end) begin
            nxt_cnt   = `SEP_CNT_ZERO;
            nxt_state = after_ff;
            nxt_oe_n  = 1'b1;
            if (after_ff == SD_RDATA) begin
              nxt_oe_n = rd_byte[7];
              nxt_sr   = {rd_byte[6:0], 1'b1};
            end
          end
        end
        SD_RDATA: begin
          if (scl_rise) begin
            nxt_cnt = cnt_ff + `SEP_CNT_ONE;
          end else if (scl_fall) begin
            if (byte_done) begin
              nxt_oe_n  = 1'b1;
              nxt_addr  = rd_inc;
              nxt_state = SD_RACK;
              nxt_cnt   = `SEP_CNT_ZERO;
            end else begin
              nxt_oe_n = sr_ff[7];
              nxt_sr   = {sr_ff[6:0], 1'b1};
            end
          end
        end
        SD_RACK: begin
          if (scl_rise) begin
            nxt_mack = (sda_s == `SEP_ACK);
            nxt_cnt  = `SEP_CNT_ONE;
          end else if (scl_fall && (cnt_ff != `SEP_CNT_ZERO)) begin
            nxt_cnt = `SEP_CNT_ZERO;
            if (mack_ff) begin
              nxt_state = SD_RDATA;
              nxt_oe_n  = rd_byte[7];
              nxt_sr    = {rd_byte[6:0], 1'b1};
            end else begin
              nxt_state = SD_IDLE;
              nxt_oe_n  = 1'b1;
            end
          end
        end
        default: begin
          nxt_state = SD_IDLE;
          nxt_oe_n  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_ff <= SD_IDLE;
      after_ff <= SD_IDLE;
      cnt_ff   <= `SEP_CNT_ZERO;
      sr_ff    <= 8'h00;
      oe_n_ff  <= 1'b1;
      mack_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      after_ff <= nxt_after;
      cnt_ff   <= nxt_cnt;
      sr_ff    <= nxt_sr;
      oe_n_ff  <= nxt_oe_n;
      mack_ff  <= nxt_mack;
    end
  end

  // counter cleared only by power-up reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_ff <= ADDR_W'(`SEP_ADDR_RST);
    end else begin
      addr_ff <= nxt_addr;
    end
  end

  // Array write at the ack decision of each data byte
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[addr_ff] <= sr_ff;
    end
  end

  assign cur_addr          = addr_ff;
  assign link.dev_sda_oe_n = oe_n_ff;
endmodule : sep_dev
`default_nettype wire

/* File: sep_host.sv */
// Controller end: makes the link clock and runs read and write sequences
`timescale 1ns/1ps
`default_nettype none
`include "sep_regs.svh"
module sep_host #(
  parameter int QTR_CYC = `SEP_QTR_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire sep_pkg::sep_kind_e cmd_kind,
  input  wire logic [2:0]        cmd_dev_sel,
  input  wire logic [7:0]        cmd_word_addr,
  input  wire logic [7:0]        cmd_wr_data,
  input  wire logic [7:0]        cmd_rd_len,
  output logic                   rd_valid,
  output logic [7:0]             rd_data,
  output logic                   done,
  output logic                   nack_err,
  sep_link_if.host               link
);
  import sep_pkg::*;

  logic [7:0]      qcnt_ff;
  logic [1:0]      sda_sy_ff;
  sep_host_state_e state_ff, nxt_state;
  sep_step_e       step_ff, nxt_step;
  sep_kind_e       kind_ff;
  logic [1:0]      ph_ff, nxt_ph;
  logic [3:0]      bit_ff, nxt_bit;
  logic [7:0]      sh_ff, nxt_sh, rx_ff, nxt_rx;
  logic [7:0]      remain_ff, nxt_remain;
  logic [2:0]      dev_ff;
  logic [7:0]      word_ff, data_ff;
  logic            scl_ff, nxt_scl, oe_n_ff, nxt_oe_n;
  logic            ready_ff, nxt_ready, rdv_ff, nxt_rdv;
  logic            done_ff, nxt_done, err_ff, nxt_err, bad_ff, nxt_bad;
  logic [7:0]      rdd_ff, nxt_rdd;

  wire        tick    = (qcnt_ff == 8'(QTR_CYC - 1));
  wire        accept  = cmd_valid & ready_ff;
  wire        is_rx   = (step_ff == SS_READ);
  wire        ack_bit = (bit_ff == `SEP_BITS_BYTE);
  // ack all but the last read byte
  wire        rx_ackv = (remain_ff > 8'h01) ? `SEP_ACK : `SEP_NACK;
  wire        bit_out = ack_bit ? (is_rx ? rx_ackv : 1'b1) : (is_rx ? 1'b1 : sh_ff[7]);

  function automatic logic [7:0] tx_of(input sep_step_e st);
    case (st)
      SS_DEVW: tx_of = {`SEP_FAMILY, dev_ff, `SEP_DIR_WR};
      SS_DEVR: tx_of = {`SEP_FAMILY, dev_ff, `SEP_DIR_RD};
      SS_WORD: tx_of = word_ff;
      SS_DATA: tx_of = data_ff;
      default: tx_of = 8'hff;
    endcase
  endfunction : tx_of

  always_comb begin
    nxt_state  = state_ff;
    nxt_step   = step_ff;
    nxt_ph     = ph_ff;
    nxt_bit    = bit_ff;
    nxt_sh     = sh_ff;
    nxt_rx     = rx_ff;
    nxt_remain = remain_ff;
    nxt_scl    = scl_ff;
    nxt_oe_n   = oe_n_ff;
    nxt_ready  = ready_ff;
    nxt_rdv    = 1'b0;
    nxt_done   = 1'b0;
    nxt_err    = err_ff;
    nxt_bad    = bad_ff;
    nxt_rdd    = rdd_ff;
    case (state_ff)
      SH_IDLE: begin
        if (accept) begin
          nxt_ready = 1'b0;
          nxt_err   = 1'b0;
          nxt_state = SH_START;
          nxt_ph    = 2'h0;
          nxt_remain = cmd_rd_len;
          // random read and write start with write address
          nxt_step  = (cmd_kind == SK_CUR) ? SS_DEVR : SS_DEVW;
        end
      end
      SH_START: begin
        if (tick) begin
          nxt_ph = ph_ff + 2'h1;
          case (ph_ff)
            2'h0: nxt_oe_n = 1'b1;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe_n = 1'b0;
            default: begin
              nxt_scl   = 1'b0;
              nxt_state = SH_BYTE;
              nxt_bit   = `SEP_CNT_ZERO;
              nxt_sh    = tx_of(step_ff);
            end
          endcase
        end
      end
      SH_BYTE: begin
        if (tick) begin
          nxt_ph = ph_ff + 2'h1;
          case (ph_ff)
            2'h0: nxt_oe_n = bit_out;
            2'h1: nxt_scl = 1'b1;
            2'h2: begin
              if (!ack_bit) nxt_rx = {rx_ff[6:0], sda_sy_ff[1]};
              else nxt_bad = ~is_rx & (sda_sy_ff[1] == `SEP_NACK);
            end
            default: begin
              nxt_scl = 1'b0;
              nxt_sh  = {sh_ff[6:0], 1'b1};
              nxt_bit = bit_ff + `SEP_CNT_ONE;
              if (ack_bit) begin
                nxt_bit = `SEP_CNT_ZERO;
                if (bad_ff) begin
                  nxt_err   = 1'b1;
                  nxt_state = SH_STOP;
                end else begin
                  case (step_ff)
                    SS_DEVW: begin
                      nxt_step = SS_WORD;
                      nxt_sh   = tx_of(SS_WORD);
                    end
                    SS_WORD: begin
                      // repeated start with no stop between
                      if (kind_ff == SK_WRITE) begin
                        nxt_step = SS_DATA;
                        nxt_sh   = tx_of(SS_DATA);
                      end else begin
                        nxt_step  = SS_DEVR;
                        nxt_state = SH_START;
                      end
                    end
                    SS_DEVR: nxt_step = SS_READ;
                    SS_READ: begin
                      nxt_rdv    = 1'b1;
                      nxt_rdd    = rx_ff;
                      nxt_remain = remain_ff - 8'h01;
                      if (remain_ff <= 8'h01) nxt_state = SH_STOP;
                    end
                    default: nxt_state = SH_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      end
      SH_STOP: begin
        if (tick) begin
          nxt_ph = ph_ff + 2'h1;
          case (ph_ff)
            2'h0: nxt_oe_n = 1'b0;
            2'h1: nxt_scl = 1'b1;
            2'h2: nxt_oe_n = 1'b1;
            default: begin
              nxt_state = SH_IDLE;
              nxt_done  = 1'b1;
              nxt_ready = 1'b1;
            end
          endcase
        end
      end
      default: nxt_state = SH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      qcnt_ff   <= 8'h00;
      sda_sy_ff <= 2'h3;
      state_ff  <= SH_IDLE;
      step_ff   <= SS_DEVW;
      ph_ff     <= 2'h0;
      bit_ff    <= `SEP_CNT_ZERO;
      sh_ff     <= 8'hff;
      rx_ff     <= 8'h00;
      remain_ff <= 8'h00;
      scl_ff    <= 1'b1;
      oe_n_ff   <= 1'b1;
      ready_ff  <= 1'b0;
      rdv_ff    <= 1'b0;
      done_ff   <= 1'b0;
      err_ff    <= 1'b0;
      bad_ff    <= 1'b0;
      rdd_ff    <= 8'h00;
    end else begin
      qcnt_ff   <= (tick || state_ff == SH_IDLE) ? 8'h00 : qcnt_ff + 8'h01;
      sda_sy_ff <= {sda_sy_ff[0], link.sda};
      state_ff  <= nxt_state;
      step_ff   <= nxt_step;
      ph_ff     <= nxt_ph;
      bit_ff    <= nxt_bit;
      sh_ff     <= nxt_sh;
      rx_ff     <= nxt_rx;
      remain_ff <= nxt_remain;
      scl_ff    <= nxt_scl;
      oe_n_ff   <= nxt_oe_n;
      ready_ff  <= nxt_ready | ((state_ff == SH_IDLE) & ~accept);
      rdv_ff    <= nxt_rdv;
      done_ff   <= nxt_done;
      err_ff    <= nxt_err;
      bad_ff    <= nxt_bad;
      rdd_ff    <= nxt_rdd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (accept) begin
      kind_ff <= cmd_kind;
      dev_ff  <= cmd_dev_sel;
      word_ff <= cmd_word_addr;
      data_ff <= cmd_wr_data;
    end
  end

  assign cmd_ready          = ready_ff;
  assign rd_valid           = rdv_ff;
  assign rd_data            = rdd_ff;
  assign done               = done_ff;
  assign nack_err           = err_ff;
  assign link.scl           = scl_ff;
  assign link.host_sda_oe_n = oe_n_ff;
endmodule : sep_host
`default_nettype wire

/* File: sep_link_chk_sva.sv */
// Assertions on the two-wire link between the controller and target ends
`timescale 1ns/1ps
`default_nettype none
module sep_link_sva (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  rst_release_a: assert property (disable iff (1'b0) sys_rst |=> dev_sda_oe_n)
    else $error("target drives data line while in reset");
  stop_release_a: assert property ($rose(sda) && scl && $past(scl) |=> dev_sda_oe_n [*8])
    else $error("target drives data line after stop");
  start_release_a: assert property ($fell(sda) && scl && $past(scl) && dev_sda_oe_n |=> dev_sda_oe_n [*8])
    else $error("target drives data line during address reception");
  no_drive_high_a: assert property (scl && $past(scl) |-> !$fell(dev_sda_oe_n))
    else $error("target starts driving while link clock high");
  drive_hold_a: assert property ($fell(dev_sda_oe_n) |=> !dev_sda_oe_n [*8])
    else $error("target low bit too short");
  release_hold_a: assert property ($rose(dev_sda_oe_n) |=> dev_sda_oe_n [*8])
    else $error("target released bit too short");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("link clock high phase too short");
  scl_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("link clock low phase too short");

  cover property ($fell(dev_sda_oe_n));
  cover property ($fell(sda) && scl && $past(scl));
  cover property ($rose(sda) && scl && $past(scl));
endmodule : sep_link_sva
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench joining the controller and target ends
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sep_pkg::*;
  localparam logic [7:0] WADDR [5] = '{8'h7e, 8'h7f, 8'h00, 8'h01, 8'h02};
  logic       ref_clk       = 1'b0;
  logic       sys_rst       = 1'b1;
  logic [2:0] strap         = 3'b101;
  logic       cmd_valid     = 1'b0;
  sep_kind_e  cmd_kind      = SK_CUR;
  logic [2:0] cmd_dev_sel   = 3'b000;
  logic [7:0] cmd_word_addr = 8'h00;
  logic [7:0] cmd_wr_data   = 8'h00;
  logic [7:0] cmd_rd_len    = 8'h01;
  logic       cmd_ready;
  logic       rd_valid;
  logic [7:0] rd_data;
  logic       done;
  logic       nack_err;
  logic [6:0] cur_addr;
  logic [7:0] rdq [$];
  logic       prev_scl      = 1'b1;
  logic       prev_sda      = 1'b1;
  logic [8:0] mon_sh        = 9'h000;
  int         mon_bits      = 0;
  int         error_cnt     = 0;
  int         compares      = 0;
  int         cyc           = 0;

  sep_link_if link ();

  always #4 ref_clk = ~ref_clk;

  sep_dev u_sep_dev (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .strap_addr_bit2(strap[2]), .strap_addr_bit1(strap[1]),
    .strap_addr_bit0(strap[0]), .cur_addr(cur_addr), .link(link)
  );
  sep_host u_sep_host (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .cmd_dev_sel(cmd_dev_sel), .cmd_word_addr(cmd_word_addr), .cmd_wr_data(cmd_wr_data),
    .cmd_rd_len(cmd_rd_len), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack_err(nack_err),
    .link(link)
  );
  sep_link_sva u_sep_link_sva (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl(link.scl), .host_sda_oe_n(link.host_sda_oe_n),
    .dev_sda_oe_n(link.dev_sda_oe_n), .sda(link.sda)
  );

  // Keeps the address byte after the latest start or repeated start and its ack bit
  always @(posedge ref_clk) begin
    prev_scl <= link.scl;
    prev_sda <= link.sda;
    if (link.scl && prev_scl && prev_sda && !link.sda) begin
      mon_bits <= 0;
    end else if (link.scl && !prev_scl && mon_bits < 9) begin
      mon_sh   <= {mon_sh[7:0], link.sda};
      mon_bits <= mon_bits + 1;
    end
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      error_cnt++;
      results();
    end
  end

  function automatic logic [7:0] wd(input logic [7:0] a);
    return a ^ 8'h3c;
  endfunction : wd

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One whole command frame; returns once done has been seen
  task automatic run(input sep_kind_e kind, input logic [2:0] sel, input logic [7:0] addr, input logic [7:0] len);
    int n;
    n = 0;
    rdq.delete();
    cmd_kind      = kind;
    cmd_dev_sel   = sel;
    cmd_word_addr = addr;
    cmd_wr_data   = wd(addr);
    cmd_rd_len    = len;
    cmd_valid     = 1'b1;
    while (cmd_ready !== 1'b1 && n < 1000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    #1 cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      if (rd_valid === 1'b1) begin
        rdq.push_back(rd_data);
      end
      n++;
    end
    if (done !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED frame done expected 1 seen %b", done);
      results();
    end else begin
      chk("ready after frame", {7'h00, cmd_ready}, 8'h01);
    end
  endtask : run

  task automatic rchk(input logic [7:0] first, input int len);
    chk("read count", 8'(rdq.size()), 8'(len));
    foreach (rdq[i]) begin
      chk("read data", rdq[i], wd((first + 8'(i)) & 8'h7f));
    end
  endtask : rchk

  initial begin
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    @(posedge ref_clk);
    #1;
    chk("counter after reset", {1'b0, cur_addr}, 8'h00);
    foreach (WADDR[i]) begin
      run(SK_WRITE, 3'b101, WADDR[i], 8'h01);
      chk("write nack", {7'h00, nack_err}, 8'h00);
      chk("write counter", {1'b0, cur_addr}, {1'b0, WADDR[i][6:3], WADDR[i][2:0] + 3'h1});
    end
    // Random read running over the top of memory
    run(SK_RAND, 3'b101, 8'h7e, 8'h04);
    rchk(8'h7e, 4);
    chk("counter after wrap", {1'b0, cur_addr}, 8'h02);
    chk("read address byte", mon_sh[8:1], {4'ha, 3'b101, 1'b1});
    chk("read address ack", {7'h00, mon_sh[0]}, 8'h00);
    run(SK_RAND, 3'b101, 8'h7f, 8'h01);
    rchk(8'h7f, 1);
    chk("counter after read", {1'b0, cur_addr}, 8'h00);
    // Current reads continue from the kept counter
    run(SK_CUR, 3'b101, 8'h55, 8'h02);
    rchk(8'h00, 2);
    run(SK_CUR, 3'b101, 8'h55, 8'h01);
    rchk(8'h02, 1);
    chk("counter kept", {1'b0, cur_addr}, 8'h03);
    // Wrong strap value gets no answer
    run(SK_CUR, 3'b010, 8'h00, 8'h01);
    chk("mismatch nack", {7'h00, nack_err}, 8'h01);
    chk("mismatch ack bit", {7'h00, mon_sh[0]}, 8'h01);
    chk("mismatch reads", 8'(rdq.size()), 8'h00);
    chk("counter untouched", {1'b0, cur_addr}, 8'h03);
    run(SK_RAND, 3'b101, 8'h01, 8'h02);
    rchk(8'h01, 2);
    results();
  end
endmodule : tb_top
`default_nettype wire
